// ---- rtl/pxa_map.svh ----
// Offsets, field positions, reset values and geometry of the pixel array addressing block.
// Assumes an AXI4-Lite master on core_clk and a camera controller driving frame and row pulses.
`ifndef PXA_MAP_SVH
`define PXA_MAP_SVH

`define PXA_REG_SEQ        8'h00
`define PXA_REG_NPIX       8'h04
`define PXA_REG_NLINES     8'h08
`define PXA_REG_INT        8'h0C
`define PXA_REG_COL_START  8'h14
`define PXA_REG_ROW_START  8'h18
`define PXA_REG_CORE       8'h1C
`define PXA_REG_DAC_RAW    8'h20
`define PXA_REG_DAC_FINE   8'h24
`define PXA_REG_STATUS     8'h28
`define PXA_REG_ADC        8'h2C

`define PXA_SEQ_NDR        0
`define PXA_SEQ_MODE_LO    1
`define PXA_SEQ_BOTH_SIDE  4
`define PXA_SEQ_DBL_SLOPE  12
`define PXA_CORE_COL_LO    2
`define PXA_CORE_ROW_LO    5

`define PXA_SEQ_RST        13'h0100
`define PXA_NPIX_RST       11'h200
`define PXA_NLINES_RST     12'hBC6
`define PXA_INT_RST        12'h001

`define PXA_BLOCK_PX       24
`define PXA_BLOCK_PAIRS    4'hC
`define PXA_COL_START_MAX  7'h62
`define PXA_ROW_START_MAX  8'h89
`define PXA_ARRAY_BLOCKS_X 92
`define PXA_ARRAY_BLOCKS_Y 125
`define PXA_COL_PAIRS      11'(((`PXA_ARRAY_BLOCKS_X * `PXA_BLOCK_PX) + 2) / 2)
`define PXA_ROW_LIMIT      12'((`PXA_ARRAY_BLOCKS_Y * `PXA_BLOCK_PX) + 2)
`define PXA_ROW_START_UNIT 12'h018

`endif

// ---- rtl/pxa_pkg.sv ----
// Types shared by the pixel array addressing block.
// Assumes pxa_map.svh carries all numeric constants.
package pxa_pkg;
  typedef logic [7:0]  pxa_addr_t;
  typedef logic [31:0] pxa_word_t;
  typedef logic [11:0] pxa_row_t;
  typedef logic [10:0] pxa_pair_t;
  typedef logic [2:0]  pxa_sub_t;
  typedef enum logic [1:0] {
    PXA_RESP_OKAY   = 2'b00,
    PXA_RESP_SLVERR = 2'b10
  } pxa_resp_e;
endpackage

// ---- rtl/pxa_sync2.sv ----
// Two-stage synchroniser, one per pin bit.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module pxa_sync2 #(
  parameter int W = 2
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // Stage one is read only by stage two
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic hold_q;
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        meta_q <= 1'b0;
        hold_q <= 1'b0;
      end else begin
        meta_q <= async_in[i];
        hold_q <= meta_q;
      end
    end
    assign sync_out[i] = hold_q;
  end
endmodule // pxa_sync2
`default_nettype wire

// ---- rtl/pxa_sub_step.sv ----
// Decoder from a subsample code to its step in pixels.
// Assumes the code is stable, taken at frame start.
`timescale 1ns/1ps
`default_nettype none
module pxa_sub_step (
  input  wire logic [2:0] code,
  output logic      [3:0] step_px
);
  // Any code with the top bit set gives the widest step
  always_comb begin
    if (code[2]) begin
      step_px = 4'hC;
    end else begin
      unique case (code[1:0])
        2'b00: step_px = 4'h2;
        2'b01: step_px = 4'h4;
        2'b10: step_px = 4'h6;
        2'b11: step_px = 4'h8;
      endcase
    end
  end
endmodule // pxa_sub_step
`default_nettype wire

// ---- rtl/pxa_top.sv ----
// Pixel array addressing: subsampled column scan, rolling shutter row pointers, DAC codes.
// Assumes frame_start_pin and row_adv_pin come from the camera controller, asynchronous.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pxa_map.svh"
module pxa_top (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               frame_start_pin,
  input  wire logic               row_adv_pin,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output pxa_pkg::pxa_pair_t      col_pair_addr,
  output logic                    col_sel_even,
  output logic                    col_sel_odd,
  output logic                    adc_even_stb,
  output logic                    adc_odd_stb,
  output pxa_pkg::pxa_row_t       row_read_addr,
  output logic                    row_read_en,
  output pxa_pkg::pxa_row_t       row_reset_addr,
  output logic                    row_reset_en,
  output logic                    row_drive_both,
  output logic                    full_reset_pulse,
  output logic [7:0]              dac_raw_code,
  output logic [7:0]              dac_fine_code
);
  import pxa_pkg::*;

  // Pin synchronisers and rising-edge detect on the synced level
  logic [1:0] pins_s;
  logic       fs_prev_q;
  logic       ra_prev_q;
  logic       frame_go;
  logic       row_go;
  pxa_sync2 #(.W(2)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({row_adv_pin, frame_start_pin}),
    .sync_out (pins_s)
  );
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fs_prev_q <= 1'b0;
      ra_prev_q <= 1'b0;
    end else begin
      fs_prev_q <= pins_s[0];
      ra_prev_q <= pins_s[1];
    end
  end
  assign frame_go = pins_s[0] & ~fs_prev_q;
  assign row_go   = pins_s[1] & ~ra_prev_q;

  // Software registers
  logic [12:0] seq_q;
  logic [10:0] npix_q;
  logic [11:0] nlines_q;
  logic [11:0] int_q;
  logic [6:0]  col_start_q;
  logic [7:0]  row_start_q;
  logic [7:0]  core_q;
  logic [7:0]  dac_raw_q;
  logic [7:0]  dac_fine_q;
  logic        adc_single_q;

  // AXI4-Lite write path: address and data latched in either order
  logic        aw_full_q;
  logic        w_full_q;
  pxa_addr_t   aw_addr_q;
  pxa_word_t   w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  pxa_word_t   wmask;
  pxa_word_t   wval;
  logic        wr_hit;
  assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_q & ~s_axi_bvalid;
  assign wr_fire = aw_full_q & w_full_q;
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wval  = w_data_q & wmask;
  always_comb begin
    unique case (aw_addr_q)
      `PXA_REG_SEQ, `PXA_REG_NPIX, `PXA_REG_NLINES, `PXA_REG_INT,
      `PXA_REG_COL_START, `PXA_REG_ROW_START, `PXA_REG_CORE,
      `PXA_REG_DAC_RAW, `PXA_REG_DAC_FINE, `PXA_REG_ADC: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_full_q    <= 1'b0;
      w_full_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PXA_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? PXA_RESP_OKAY : PXA_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register stores; bytes left out by wstrb keep their value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seq_q        <= `PXA_SEQ_RST;
      npix_q       <= `PXA_NPIX_RST;
      nlines_q     <= `PXA_NLINES_RST;
      int_q        <= `PXA_INT_RST;
      col_start_q  <= 7'h00;
      row_start_q  <= 8'h00;
      core_q       <= 8'h00;
      dac_raw_q    <= 8'h00;
      dac_fine_q   <= 8'h00;
      adc_single_q <= 1'b0;
    end else if (wr_fire) begin
      unique case (aw_addr_q)
        `PXA_REG_SEQ:    seq_q <= (seq_q & ~wmask[12:0]) | wval[12:0];
        `PXA_REG_NPIX:   npix_q <= (npix_q & ~wmask[10:0]) | wval[10:0];
        `PXA_REG_NLINES: nlines_q <= (nlines_q & ~wmask[11:0]) | wval[11:0];
        `PXA_REG_INT:    int_q <= (int_q & ~wmask[11:0]) | wval[11:0];
        // Out-of-range starts saturate at the last coordinate
        `PXA_REG_COL_START: if (w_strb_q[0]) begin
          col_start_q <= (w_data_q[6:0] > `PXA_COL_START_MAX) ?
                         `PXA_COL_START_MAX : w_data_q[6:0];
        end
        `PXA_REG_ROW_START: if (w_strb_q[0]) begin
          row_start_q <= (w_data_q[7:0] > `PXA_ROW_START_MAX) ?
                         `PXA_ROW_START_MAX : w_data_q[7:0];
        end
        `PXA_REG_CORE:     if (w_strb_q[0]) core_q <= w_data_q[7:0];
        `PXA_REG_DAC_RAW:  if (w_strb_q[0]) dac_raw_q <= w_data_q[7:0];
        `PXA_REG_DAC_FINE: if (w_strb_q[0]) dac_fine_q <= w_data_q[7:0];
        `PXA_REG_ADC:      if (w_strb_q[0]) adc_single_q <= w_data_q[0];
        default: ;
      endcase
    end
  end

  // Frame-latched configuration so mid-frame writes wait for the next frame
  pxa_sub_t   col_sub_f_q;
  pxa_sub_t   row_sub_f_q;
  logic [6:0] col_start_f_q;
  logic       both_f_q;
  logic       single_f_q;
  logic       both_sel;
  assign both_sel = seq_q[`PXA_SEQ_BOTH_SIDE] | (seq_q[`PXA_SEQ_NDR] &
    ((seq_q[`PXA_SEQ_MODE_LO +: 2] == 2'b01) | (seq_q[`PXA_SEQ_MODE_LO +: 2] == 2'b10)));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      col_sub_f_q   <= 3'h0;
      row_sub_f_q   <= 3'h0;
      col_start_f_q <= 7'h00;
      both_f_q      <= 1'b0;
      single_f_q    <= 1'b0;
    end else if (frame_go) begin
      col_sub_f_q   <= core_q[`PXA_CORE_COL_LO +: 3];
      row_sub_f_q   <= core_q[`PXA_CORE_ROW_LO +: 3];
      col_start_f_q <= col_start_q;
      both_f_q      <= both_sel;
      single_f_q    <= adc_single_q;
    end
  end
  assign row_drive_both = both_f_q;

  // Step decoders for both directions
  logic [3:0] col_step_px;
  logic [3:0] row_step_px;
  pxa_sub_step u_col_step (
    .code    (col_sub_f_q),
    .step_px (col_step_px)
  );
  pxa_sub_step u_row_step (
    .code    (row_sub_f_q),
    .step_px (row_step_px)
  );

  // Next row: second row of the pair, or jump over the skipped rows
  function automatic pxa_row_t next_row(input pxa_row_t ptr, input logic ph,
                                        input logic [3:0] step);
    next_row = ph ? ptr + 12'(step) - 12'h001 : ptr + 12'h001;
  endfunction

  // Row pointers: reset leads, read trails by the integration row count
  pxa_row_t   rst_ptr_q;
  pxa_row_t   rd_ptr_q;
  logic       rst_ph_q;
  logic       rd_ph_q;
  pxa_row_t   lag_q;
  logic       rd_act_q;
  pxa_row_t   rd_cnt_q;
  pxa_row_t   row_base;
  logic       row_go_rd;
  assign row_base  = 12'(row_start_q) * `PXA_ROW_START_UNIT;
  // Read joins on the advance that leaves the reset row int_q rows ahead
  assign row_go_rd = row_go & (rd_act_q | ({1'b0, lag_q} + 13'h0001 >= {1'b0, int_q}));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_ptr_q <= 12'h000;
      rst_ph_q  <= 1'b0;
      lag_q     <= 12'h000;
    end else if (frame_go) begin
      rst_ptr_q <= row_base;
      rst_ph_q  <= 1'b0;
      lag_q     <= 12'h000;
    end else if (row_go) begin
      rst_ptr_q <= next_row(rst_ptr_q, rst_ph_q, row_step_px);
      rst_ph_q  <= ~rst_ph_q;
      if (lag_q != 12'hFFF) lag_q <= lag_q + 12'h001;
    end
  end
  // The read pointer starts on the base row, int_q rows behind the reset row
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_ptr_q <= 12'h000;
      rd_ph_q  <= 1'b0;
      rd_act_q <= 1'b0;
      rd_cnt_q <= 12'h000;
    end else if (frame_go) begin
      rd_ptr_q <= row_base;
      rd_ph_q  <= 1'b0;
      rd_act_q <= 1'b0;
      rd_cnt_q <= 12'h000;
    end else if (row_go_rd) begin
      rd_act_q <= 1'b1;
      rd_cnt_q <= rd_cnt_q + 12'h001;
      if (rd_act_q) begin
        rd_ptr_q <= next_row(rd_ptr_q, rd_ph_q, row_step_px);
        rd_ph_q  <= ~rd_ph_q;
      end
    end
  end

  // Row line drivers; read stops after nlines rows or at the array edge
  logic rd_in_frame;
  logic rst_in_frame;
  assign rd_in_frame  = rd_act_q & (rd_cnt_q <= nlines_q) & (rd_ptr_q < `PXA_ROW_LIMIT);
  assign rst_in_frame = rst_ptr_q < `PXA_ROW_LIMIT;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      row_read_addr    <= 12'h000;
      row_read_en      <= 1'b0;
      row_reset_addr   <= 12'h000;
      row_reset_en     <= 1'b0;
      full_reset_pulse <= 1'b0;
    end else begin
      row_read_addr    <= rd_ptr_q;
      row_read_en      <= rd_in_frame;
      row_reset_addr   <= rst_ptr_q;
      row_reset_en     <= rst_in_frame;
      // High-sensitivity slope: whole array reset once per frame
      // Bit read live so the first frame after enabling also gets its reset
      full_reset_pulse <= frame_go & seq_q[`PXA_SEQ_DBL_SLOPE];
    end
  end

  // Column scan in pairs: block index plus pair offset inside the block
  logic [6:0] blk_q;
  logic [3:0] off_q;
  logic [10:0] pcnt_q;
  logic       line_q;
  logic       half_q;
  logic [3:0] step_pairs;
  logic [4:0] off_sum;
  pxa_pair_t  pair_addr;
  logic       advance;
  assign step_pairs = {1'b0, col_step_px[3:1]};
  assign off_sum    = {1'b0, off_q} + {1'b0, step_pairs};
  assign pair_addr  = 11'(blk_q) * 11'(`PXA_BLOCK_PAIRS) + 11'(off_q);
  // A single converter takes two cycles per pair: even then odd
  assign advance    = line_q & (~single_f_q | half_q);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blk_q  <= 7'h00;
      off_q  <= 4'h0;
      pcnt_q <= 11'h000;
      line_q <= 1'b0;
      half_q <= 1'b0;
    end else if (frame_go) begin
      line_q <= 1'b0;
      half_q <= 1'b0;
    end else if (row_go_rd) begin
      blk_q  <= col_start_f_q;
      off_q  <= 4'h0;
      pcnt_q <= 11'h000;
      line_q <= 1'b1;
      half_q <= 1'b0;
    end else if (line_q) begin
      half_q <= ~half_q;
      if (advance) begin
        if (off_sum >= {1'b0, `PXA_BLOCK_PAIRS}) begin
          blk_q <= blk_q + 7'h01;
          off_q <= 4'(off_sum - {1'b0, `PXA_BLOCK_PAIRS});
        end else begin
          off_q <= off_sum[3:0];
        end
        pcnt_q <= pcnt_q + 11'h001;
        if ((pcnt_q + 11'h001 >= npix_q) || (pair_addr >= `PXA_COL_PAIRS - 11'h001)) begin
          line_q <= 1'b0;
        end
      end
    end
  end

  // Column selects and converter strobes, registered
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      col_pair_addr <= 11'h000;
      col_sel_even  <= 1'b0;
      col_sel_odd   <= 1'b0;
      adc_even_stb  <= 1'b0;
      adc_odd_stb   <= 1'b0;
    end else begin
      col_pair_addr <= pair_addr;
      col_sel_even  <= line_q;
      col_sel_odd   <= line_q;
      adc_even_stb  <= line_q & (~single_f_q | ~half_q);
      adc_odd_stb   <= line_q & (~single_f_q | half_q);
    end
  end

  // Offset DAC codes; fine code moves only bus two's reference
  assign dac_raw_code  = dac_raw_q;
  assign dac_fine_code = dac_fine_q;

  // AXI4-Lite read path, one read at a time
  pxa_word_t rd_word;
  logic      rd_hit;
  assign s_axi_arready = ~s_axi_rvalid;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      `PXA_REG_SEQ:       rd_word[12:0] = seq_q;
      `PXA_REG_NPIX:      rd_word[10:0] = npix_q;
      `PXA_REG_NLINES:    rd_word[11:0] = nlines_q;
      `PXA_REG_INT:       rd_word[11:0] = int_q;
      `PXA_REG_COL_START: rd_word[6:0] = col_start_q;
      `PXA_REG_ROW_START: rd_word[7:0] = row_start_q;
      `PXA_REG_CORE:      rd_word[7:0] = core_q;
      `PXA_REG_DAC_RAW:   rd_word[7:0] = dac_raw_q;
      `PXA_REG_DAC_FINE:  rd_word[7:0] = dac_fine_q;
      `PXA_REG_ADC:       rd_word[0] = adc_single_q;
      `PXA_REG_STATUS:    rd_word = {line_q, rd_act_q, 2'b00, rst_ptr_q, 4'h0, rd_ptr_q};
      default:            rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= PXA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? PXA_RESP_OKAY : PXA_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pxa_top
`default_nettype wire

// ---- tb/pxa_top_monitor.sv ----
// Port-level checker for the pixel array addressing block, bound into pxa_top.
// Assumes a single core_clk domain and the active-high asynchronous reset rst.
`timescale 1ns/1ps
`default_nettype none
module pxa_chk (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              frame_start_pin,
  input wire logic              s_axi_bvalid,
  input wire pxa_pkg::pxa_pair_t col_pair_addr,
  input wire logic              col_sel_even,
  input wire logic              col_sel_odd,
  input wire logic              adc_even_stb,
  input wire logic              adc_odd_stb,
  input wire pxa_pkg::pxa_row_t  row_read_addr,
  input wire logic              row_read_en,
  input wire pxa_pkg::pxa_row_t  row_reset_addr,
  input wire logic              row_reset_en,
  input wire logic              row_drive_both,
  input wire logic [7:0]        dac_raw_code
);
  import pxa_pkg::*;
  logic [3:0] fs_age_q;

  // Cycles since the frame pin was high, saturating; setup may only move just after a frame
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      fs_age_q <= 4'h0;
    else if (frame_start_pin)
      fs_age_q <= 4'h0;
    else if (fs_age_q != 4'hF)
      fs_age_q <= fs_age_q + 4'h1;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_pair_sel: assert property (col_sel_even == col_sel_odd)
    else $error("odd and even column selects differ");
  a_strobe_line: assert property ((adc_even_stb || adc_odd_stb) |-> (col_sel_even || $past(col_sel_even)))
    else $error("converter strobe outside a column line");
  a_row_lockstep: assert property (row_read_en && $changed(row_read_addr) |-> $changed(row_reset_addr))
    else $error("read row moved without the reset row");
  a_row_single: assert property ($changed(row_reset_addr) |=> $stable(row_reset_addr) [*4])
    else $error("reset row moved twice for one advance");
  a_reset_lead: assert property (row_read_en && row_reset_en |-> row_reset_addr >= row_read_addr)
    else $error("reset row behind read row");
  a_read_follows: assert property ($rose(row_read_en) |-> row_reset_en)
    else $error("read row active without a reset row");
  a_both_frame: assert property ($changed(row_drive_both) |-> fs_age_q < 4'h6)
    else $error("both-side drive changed mid frame");
  a_dac_write: assert property ($changed(dac_raw_code) |-> $rose(s_axi_bvalid))
    else $error("offset code changed without a write");
  a_col_rise: assert property (col_sel_even && $past(col_sel_even) && $changed(col_pair_addr)
                               |-> col_pair_addr > $past(col_pair_addr))
    else $error("column pair address stepped backwards in a line");
endmodule // pxa_chk

bind pxa_top pxa_chk u_chk (
  .core_clk(core_clk), .rst(rst), .frame_start_pin(frame_start_pin),
  .s_axi_bvalid(s_axi_bvalid), .col_pair_addr(col_pair_addr),
  .col_sel_even(col_sel_even), .col_sel_odd(col_sel_odd),
  .adc_even_stb(adc_even_stb), .adc_odd_stb(adc_odd_stb),
  .row_read_addr(row_read_addr), .row_read_en(row_read_en),
  .row_reset_addr(row_reset_addr), .row_reset_en(row_reset_en),
  .row_drive_both(row_drive_both), .dac_raw_code(dac_raw_code)
);
`default_nettype wire

// ---- tb/pxa_ctl_model.sv ----
// Camera controller model: frame-start and row-advance pulses.
// Assumes the bench calls pulse() and keeps rows spaced longer than a line.
`timescale 1ns/1ps
`default_nettype none
module pxa_ctl_model (
  input wire logic core_clk,
  output logic     frame_start_pin,
  output logic     row_adv_pin
);
  initial begin
    frame_start_pin = 1'b0;
    row_adv_pin = 1'b0;
  end

  // Pulse held four cycles so the two-stage synchroniser cannot miss it
  task automatic pulse(input bit row, input int gap);
    @(posedge core_clk);
    if (row)
      row_adv_pin <= 1'b1;
    else
      frame_start_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    row_adv_pin <= 1'b0;
    frame_start_pin <= 1'b0;
    repeat (gap) @(posedge core_clk);
  endtask
endmodule // pxa_ctl_model
`default_nettype wire

// ---- tb/tb_pixel_array_subsample_shutter_addressing.sv ----
// Self-checking bench for the pixel array addressing block.
// Assumes pxa_top, the controller model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pxa_map.svh"
module tb_pixel_array_subsample_shutter_addressing;
  import pxa_pkg::*;
  logic        core_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, draw, dfine;
  logic [31:0] wdata, d;
  wire         fs, ra, awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  pxa_pair_t   cpa, first, delta, last;
  pxa_row_t    rda, rsa;
  logic        ce, co, ae, ao, re, se, both, frp, prev;
  logic [1:0]  r;
  int          failures, compares, cyc, nfr, ndiff, nboth, n0, n1;
  localparam logic [7:0]  RA [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h20};
  localparam logic [31:0] RV [8] = '{32'h100, 32'h200, 32'hBC6, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] SQ [6] = '{32'h10, 32'h3, 32'h5, 32'h7, 32'h1, 32'h0};
  localparam logic [31:0] SB [6] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] ST [8] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h6, 32'h6, 32'h6, 32'h6};

  pxa_ctl_model u_ctl (.core_clk(core_clk), .frame_start_pin(fs), .row_adv_pin(ra));
  pxa_top uut (
    .core_clk(core_clk), .rst(rst), .frame_start_pin(fs), .row_adv_pin(ra),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .col_pair_addr(cpa), .col_sel_even(ce), .col_sel_odd(co), .adc_even_stb(ae),
    .adc_odd_stb(ao), .row_read_addr(rda), .row_read_en(re), .row_reset_addr(rsa),
    .row_reset_en(se), .row_drive_both(both), .full_reset_pulse(frp),
    .dac_raw_code(draw), .dac_fine_code(dfine)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  // Address and data offered together; each is dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge core_clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge core_clk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    while (bvalid !== 1'b1) @(posedge core_clk);
    bready <= 1'b0;
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  // Line observer: first pair, last step, strobe pairing, plus the hang limit
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (frp === 1'b1) nfr <= nfr + 1;
    if (ae === 1'b1 && ao === 1'b1) nboth <= nboth + 1;
    if ((ce === 1'b1 && ae !== ao) || ce !== co) ndiff <= ndiff + 1;
    if (ce === 1'b1 && prev !== 1'b1) first <= cpa;
    if (ce === 1'b1 && prev === 1'b1) delta <= cpa - last;
    prev <= ce;
    last <= cpa;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata} = '0;
    {failures, compares, cyc, nfr, ndiff, nboth} = '0;
    prev = 1'b0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    foreach (RA[i]) begin
      rd(RA[i]);
      chk("reset value", RV[i], d);
    end
    rd(8'h10);
    chk("unmapped read resp", 2'b10, r);
    wr(8'h30, 32'h1);
    chk("unmapped write resp", 2'b10, r);
    $display("test registers done");
    wr(`PXA_REG_DAC_RAW, 32'hFF);
    wr(`PXA_REG_DAC_FINE, 32'h0);
    chk("dac raw", 32'hFF, draw);
    chk("dac fine", 32'h0, dfine);
    wr(`PXA_REG_DAC_RAW, 32'h0);
    wr(`PXA_REG_DAC_FINE, 32'hFF);
    chk("dac raw", 32'h0, draw);
    chk("dac fine", 32'hFF, dfine);
    $display("test offset codes done");
    n0 = nfr;
    for (int i = 0; i < 6; i++) begin
      wr(`PXA_REG_SEQ, SQ[i]);
      u_ctl.pulse(1'b0, 8);
      chk("row_drive_both", SB[i], both);
    end
    chk("full reset pulses", 0, nfr - n0);
    wr(`PXA_REG_SEQ, 32'h1000);
    n0 = nfr;
    u_ctl.pulse(1'b0, 8);
    chk("full reset pulses", 1, nfr - n0);
    wr(`PXA_REG_SEQ, 32'h0);
    $display("test sequencer modes done");
    wr(`PXA_REG_ROW_START, 32'h2);
    wr(`PXA_REG_INT, 32'h3);
    wr(`PXA_REG_NPIX, 32'h8);
    u_ctl.pulse(1'b0, 8);
    chk("read row base", 2 * 24, rda);
    chk("reset row base", 2 * 24, rsa);
    repeat (5) u_ctl.pulse(1'b1, 40);
    chk("reset row", 2 * 24 + 5, rsa);
    chk("row lag", 3, rsa - rda);
    chk("read enable", 1, re);
    chk("reset enable", 1, se);
    wr(`PXA_REG_CORE, 32'h20);
    u_ctl.pulse(1'b0, 8);
    repeat (2) u_ctl.pulse(1'b1, 40);
    chk("row subsample", 2 * 24 + 4, rsa);
    $display("test rolling shutter done");
    wr(`PXA_REG_INT, 32'h1);
    wr(`PXA_REG_COL_START, 32'h1);
    n0 = ndiff;
    for (int c = 0; c < 8; c++) begin
      wr(`PXA_REG_CORE, 32'(c) << 2);
      u_ctl.pulse(1'b0, 8);
      u_ctl.pulse(1'b1, 40);
      chk("first pair", 12, first);
      chk("pair step", ST[c], delta);
    end
    chk("dual strobes", 0, ndiff - n0);
    wr(`PXA_REG_ADC, 32'h1);
    n0 = nboth;
    n1 = ndiff;
    u_ctl.pulse(1'b0, 8);
    u_ctl.pulse(1'b1, 40);
    chk("single strobes", 0, nboth - n0);
    chk("single strobe count", 16, ndiff - n1);
    $display("test column scan done");
    test_done();
  end
endmodule // tb_pixel_array_subsample_shutter_addressing
`default_nettype wire
